// [rtl/lsl_consts.svh]
// timing and framing constants for the single-wire slave-node link
`ifndef LSL_CONSTS_SVH
`define LSL_CONSTS_SVH

// ----------------------------------------------------------------
// clock and nominal bit rate
// ----------------------------------------------------------------
`define LSL_CLK_HZ 200000000
`define LSL_BAUD 19200
`define LSL_BIT_CYC (`LSL_CLK_HZ / `LSL_BAUD)

// ----------------------------------------------------------------
// header and byte timing, in bit times
// ----------------------------------------------------------------
`define LSL_BREAK_BITS 13
`define LSL_BREAK_MIN_BITS 10
`define LSL_GAP_BITS 14
`define LSL_FRAME_LAST 4'ha
`define LSL_STOP_IDX 4'h9

// ----------------------------------------------------------------
// fixed values
// ----------------------------------------------------------------
`define LSL_SYNC_BYTE 8'h55
`define LSL_SYNC_LAST_FALL 3'h3
`define LSL_XCVR_RST 1'b1

`endif

// [rtl/lsl_pkg.sv]
// types and shared decoding for the single-wire slave-node link
package lsl_pkg;

    // ----------------------------------------------------------------
    // frame table kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        lsl_k_ignore,
        lsl_k_publish,
        lsl_k_subscribe,
        lsl_k_event,
        lsl_k_diag
    } lsl_kind_t;

    // ----------------------------------------------------------------
    // state machines
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ss_idle, ss_brk, ss_sync_wait, ss_sync, ss_rx_wait, ss_rx_bits, ss_tx
    } lsl_sst_t;

    typedef enum logic [2:0] {
        ms_idle, ms_brk, ms_tx, ms_rx_wait, ms_rx_bits
    } lsl_mst_t;

    typedef struct packed {
        lsl_sst_t st;
        logic [63:0][6:0] tbl;
        logic [15:0] bit_len;
        logic [19:0] cnt;
        logic [19:0] low_cnt;
        logic [3:0] bitn;
        logic [2:0] falls;
        logic [10:0] sh;
        logic is_pid;
        logic [3:0] left;
        logic prev;
        logic bus_o;
        logic bus_oe;
        logic xcvr_en;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_err;
        logic hdr_valid;
        logic [5:0] hdr_id;
        logic tx_pop;
    } lsl_slave_t;

    typedef struct packed {
        lsl_mst_t st;
        logic [19:0] cnt;
        logic [3:0] bitn;
        logic [10:0] sh;
        logic [1:0] phase;
        logic [3:0] left;
        logic send;
        logic [5:0] id;
        logic prev;
        logic bus_o;
        logic bus_oe;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_err;
        logic tx_pop;
        logic done;
        logic no_resp;
        logic busy;
    } lsl_master_t;

    // ----------------------------------------------------------------
    // protected identifier: two parity bits above the six id bits
    // ----------------------------------------------------------------
    function automatic logic [7:0] lsl_pid(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction

    // transmit pattern: idle bit, start bit, data lsb first, stop bit
    function automatic logic [10:0] lsl_tx_frame(input logic [7:0] data);
        return {1'b1, data, 1'b0, 1'b1};
    endfunction

endpackage

// [rtl/lsl_if.sv]
// single-wire bus between master end and slave end, with wired-and resolution
`timescale 1ns/1ps
interface lsl_if;
    logic m_bus_o;
    logic m_bus_oe;
    logic s_bus_o;
    logic s_bus_oe;
    logic transceiver_enable_pin;
    logic bus_i;

    // a disabled transceiver cannot pull the wire low
    assign bus_i = ~((m_bus_oe & ~m_bus_o)
        | (transceiver_enable_pin & s_bus_oe & ~s_bus_o));

    modport master_mp (
        input bus_i,
        output m_bus_o,
        output m_bus_oe
    );

    modport slave_mp (
        input bus_i,
        output s_bus_o,
        output s_bus_oe,
        output transceiver_enable_pin
    );
endinterface

// [rtl/lsl_master.sv]
// master end: sends headers, then sends or collects the response bytes
`timescale 1ns/1ps
`include "lsl_consts.svh"
module lsl_master #(
    parameter int BIT_CYC = `LSL_BIT_CYC,
    parameter int GAP_CYC = `LSL_BIT_CYC * `LSL_GAP_BITS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    lsl_if.master_mp lnk,
    input wire logic hdr_req,
    input wire logic [5:0] hdr_id,
    input wire logic [3:0] hdr_len,
    input wire logic hdr_send,
    input wire logic [7:0] tx_data,
    output logic tx_pop,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_err,
    output logic done,
    output logic no_resp,
    output logic busy
);
    localparam lsl_pkg::lsl_master_t MRST = '{st: lsl_pkg::ms_idle, prev: 1'b1,
        bus_o: 1'b1, default: '0};

    lsl_pkg::lsl_master_t r;
    lsl_pkg::lsl_master_t next_r;
    logic fell;
    logic bit_end;
    logic [10:0] rx_sh;

    assign fell = r.prev & ~lnk.bus_i;
    assign bit_end = (r.cnt == 20'(BIT_CYC - 1));
    assign rx_sh = {lnk.bus_i, r.sh[10:1]};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.prev = lnk.bus_i;
        next_r.rx_valid = 1'b0;
        next_r.rx_err = 1'b0;
        next_r.tx_pop = 1'b0;
        next_r.done = 1'b0;
        next_r.no_resp = 1'b0;
        next_r.cnt = bit_end ? 20'h0 : r.cnt + 20'h1;
        case (r.st)
            lsl_pkg::ms_idle: begin
                next_r.cnt = 20'h0;
                if (hdr_req) begin
                    next_r.st = lsl_pkg::ms_brk;
                    next_r.bitn = 4'h0;
                    next_r.id = hdr_id;
                    next_r.left = hdr_len;
                    next_r.send = hdr_send;
                end
            end
            lsl_pkg::ms_brk: begin
                if (bit_end) begin
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.bitn == 4'(`LSL_BREAK_BITS - 1)) begin
                        // the leading idle bit of the sync frame is the delimiter
                        next_r.st = lsl_pkg::ms_tx;
                        next_r.sh = lsl_pkg::lsl_tx_frame(`LSL_SYNC_BYTE);
                        next_r.bitn = 4'h0;
                        next_r.phase = 2'h0;
                    end
                end
            end
            lsl_pkg::ms_tx: begin
                if (bit_end) begin
                    next_r.bitn = r.bitn + 4'h1;
                    next_r.sh = {1'b1, r.sh[10:1]};
                    if (r.bitn == `LSL_FRAME_LAST) begin
                        next_r.bitn = 4'h0;
                        if (r.phase == 2'h0) begin
                            next_r.sh = lsl_pkg::lsl_tx_frame(lsl_pkg::lsl_pid(r.id));
                            next_r.phase = 2'h1;
                        end else if (r.left == 4'h0) begin
                            next_r.st = lsl_pkg::ms_idle;
                            next_r.done = 1'b1;
                        end else if (r.send) begin
                            // master publishes: sporadic, request, or own data
                            next_r.sh = lsl_pkg::lsl_tx_frame(tx_data);
                            next_r.tx_pop = 1'b1;
                            next_r.left = r.left - 4'h1;
                            next_r.phase = 2'h2;
                        end else begin
                            next_r.st = lsl_pkg::ms_rx_wait;
                            next_r.cnt = 20'h0;
                            next_r.phase = 2'h2;
                        end
                    end
                end
            end
            lsl_pkg::ms_rx_wait: begin
                next_r.cnt = r.cnt + 20'h1;
                if (fell) begin
                    next_r.st = lsl_pkg::ms_rx_bits;
                    next_r.cnt = 20'h0;
                    next_r.bitn = 4'h0;
                end else if (r.cnt == 20'(GAP_CYC - 1)) begin
                    // a silent slave ends the frame here
                    next_r.st = lsl_pkg::ms_idle;
                    next_r.no_resp = 1'b1;
                    next_r.done = 1'b1;
                end
            end
            lsl_pkg::ms_rx_bits: begin
                if (r.cnt == 20'(BIT_CYC / 2)) begin
                    next_r.sh = rx_sh;
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.bitn == 4'h0 && lnk.bus_i) begin
                        next_r.st = lsl_pkg::ms_rx_wait;
                    end else if (r.bitn == `LSL_STOP_IDX) begin
                        if (!rx_sh[10]) begin
                            // garbled byte, often two publishers colliding
                            next_r.rx_err = 1'b1;
                            next_r.st = lsl_pkg::ms_idle;
                            next_r.done = 1'b1;
                        end else begin
                            next_r.rx_data = rx_sh[9:2];
                            next_r.rx_valid = 1'b1;
                            next_r.left = r.left - 4'h1;
                            next_r.st = (r.left == 4'h1) ? lsl_pkg::ms_idle
                                : lsl_pkg::ms_rx_wait;
                            next_r.done = (r.left == 4'h1);
                            next_r.cnt = 20'h0;
                        end
                    end
                end
            end
            default: next_r.st = lsl_pkg::ms_idle;
        endcase
        next_r.busy = (next_r.st != lsl_pkg::ms_idle);
        next_r.bus_o = (next_r.st == lsl_pkg::ms_tx) ? next_r.sh[0] : 1'b1;
        next_r.bus_oe = (next_r.st == lsl_pkg::ms_brk)
            | ((next_r.st == lsl_pkg::ms_tx) & ~next_r.sh[0]);
        if (next_r.st == lsl_pkg::ms_brk) begin
            next_r.bus_o = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= MRST;
        end else begin
            r <= next_r;
        end
    end

    assign lnk.m_bus_o = r.bus_o;
    assign lnk.m_bus_oe = r.bus_oe;
    assign tx_pop = r.tx_pop;
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;
    assign rx_err = r.rx_err;
    assign done = r.done;
    assign no_resp = r.no_resp;
    assign busy = r.busy;
endmodule

// [rtl/lsl_slave.sv]
// slave end: header capture with bit-rate measurement and response handling
`timescale 1ns/1ps
`include "lsl_consts.svh"
module lsl_slave #(
    parameter int BIT_CYC = `LSL_BIT_CYC,
    parameter int BREAK_MIN_CYC = `LSL_BIT_CYC * `LSL_BREAK_MIN_BITS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    lsl_if.slave_mp lnk,
    input wire logic link_enable,
    input wire logic tbl_we,
    input wire logic [5:0] tbl_id,
    input wire lsl_pkg::lsl_kind_t tbl_kind,
    input wire logic [3:0] tbl_len,
    input wire logic pub_ready,
    input wire logic [7:0] tx_data,
    output logic tx_pop,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_err,
    output logic hdr_valid,
    output logic [5:0] hdr_id,
    output logic [15:0] bit_len
);
    localparam lsl_pkg::lsl_slave_t SRST = '{st: lsl_pkg::ss_idle,
        bit_len: 16'(BIT_CYC), prev: 1'b1, bus_o: 1'b1,
        xcvr_en: `LSL_XCVR_RST, default: '0};

    lsl_pkg::lsl_slave_t r;
    lsl_pkg::lsl_slave_t next_r;
    logic header_capture_input;
    logic fell;
    logic bit_end;
    logic mid_bit;
    logic [10:0] rx_sh;
    logic [19:0] span;
    lsl_pkg::lsl_kind_t kind;
    logic [3:0] len;
    logic answer;

    // the capture path watches the same wire as the serial receiver
    assign header_capture_input = lnk.bus_i;
    assign fell = r.prev & ~header_capture_input;
    assign bit_end = (r.cnt == {4'h0, r.bit_len} - 20'h1);
    assign mid_bit = (r.cnt == {5'h0, r.bit_len[15:1]});
    assign rx_sh = {header_capture_input, r.sh[10:1]};
    assign span = r.cnt + 20'h1;
    assign kind = lsl_pkg::lsl_kind_t'(r.tbl[rx_sh[7:2]][6:4]);
    assign len = r.tbl[rx_sh[7:2]][3:0];

    // ----------------------------------------------------------------
    // publish decision for the identifier now in the shifter
    // ----------------------------------------------------------------
    always_comb begin
        case (kind)
            lsl_pkg::lsl_k_publish: answer = 1'b1;
            lsl_pkg::lsl_k_event: answer = pub_ready;
            lsl_pkg::lsl_k_diag: answer = pub_ready;
            default: answer = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.prev = header_capture_input;
        next_r.rx_valid = 1'b0;
        next_r.rx_err = 1'b0;
        next_r.hdr_valid = 1'b0;
        next_r.tx_pop = 1'b0;
        next_r.xcvr_en = link_enable;
        if (tbl_we) begin
            next_r.tbl[tbl_id] = {tbl_kind, tbl_len};
        end
        // low-time counter runs in every state so a break resyncs whenever the transceiver is enabled
        if (header_capture_input) begin
            next_r.low_cnt = 20'h0;
        end else if (r.low_cnt != 20'(BREAK_MIN_CYC)) begin
            next_r.low_cnt = r.low_cnt + 20'h1;
        end
        next_r.cnt = bit_end ? 20'h0 : r.cnt + 20'h1;
        case (r.st)
            lsl_pkg::ss_idle: begin
                next_r.cnt = 20'h0;
            end
            lsl_pkg::ss_brk: begin
                next_r.cnt = 20'h0;
                if (header_capture_input) begin
                    next_r.st = lsl_pkg::ss_sync_wait;
                end
            end
            lsl_pkg::ss_sync_wait: begin
                next_r.cnt = 20'h0;
                if (fell) begin
                    next_r.st = lsl_pkg::ss_sync;
                    next_r.falls = 3'h0;
                end
            end
            lsl_pkg::ss_sync: begin
                // sync byte has five falling edges spaced over eight bit times
                next_r.cnt = r.cnt + 20'h1;
                if (fell) begin
                    next_r.falls = r.falls + 3'h1;
                    if (r.falls == `LSL_SYNC_LAST_FALL) begin
                        next_r.bit_len = {1'b0, span[17:3]};
                        next_r.st = lsl_pkg::ss_rx_wait;
                        next_r.is_pid = 1'b1;
                        next_r.cnt = 20'h0;
                    end
                end else if (r.cnt == 20'hfffff) begin
                    next_r.st = lsl_pkg::ss_idle;
                end
            end
            lsl_pkg::ss_rx_wait: begin
                next_r.cnt = 20'h0;
                if (fell) begin
                    next_r.st = lsl_pkg::ss_rx_bits;
                    next_r.bitn = 4'h0;
                end
            end
            lsl_pkg::ss_rx_bits: begin
                if (mid_bit) begin
                    next_r.sh = rx_sh;
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.bitn == 4'h0 && header_capture_input) begin
                        // glitch, not a start bit
                        next_r.st = lsl_pkg::ss_rx_wait;
                    end else if (r.bitn == `LSL_STOP_IDX) begin
                        next_r.st = lsl_pkg::ss_idle;
                        if (!rx_sh[10]) begin
                            next_r.rx_err = 1'b1;
                        end else if (r.is_pid) begin
                            if (lsl_pkg::lsl_pid(rx_sh[7:2]) != rx_sh[9:2]) begin
                                next_r.rx_err = 1'b1;
                            end else begin
                                next_r.hdr_valid = 1'b1;
                                next_r.hdr_id = rx_sh[7:2];
                                next_r.is_pid = 1'b0;
                                if (answer && len != 4'h0) begin
                                    next_r.st = lsl_pkg::ss_tx;
                                    next_r.sh = lsl_pkg::lsl_tx_frame(tx_data);
                                    next_r.tx_pop = 1'b1;
                                    next_r.left = len - 4'h1;
                                    next_r.bitn = 4'h0;
                                    next_r.cnt = 20'h0;
                                end else if (kind == lsl_pkg::lsl_k_subscribe
                                        && len != 4'h0) begin
                                    next_r.st = lsl_pkg::ss_rx_wait;
                                    next_r.left = len;
                                end
                            end
                        end else begin
                            next_r.rx_data = rx_sh[9:2];
                            next_r.rx_valid = 1'b1;
                            next_r.left = r.left - 4'h1;
                            if (r.left != 4'h1) begin
                                next_r.st = lsl_pkg::ss_rx_wait;
                            end
                        end
                    end
                end
            end
            lsl_pkg::ss_tx: begin
                if (mid_bit && header_capture_input != r.sh[0]) begin
                    // readback mismatch: another node won the bus, back off
                    next_r.rx_err = 1'b1;
                    next_r.st = lsl_pkg::ss_idle;
                end else if (bit_end) begin
                    next_r.bitn = r.bitn + 4'h1;
                    next_r.sh = {1'b1, r.sh[10:1]};
                    if (r.bitn == `LSL_FRAME_LAST) begin
                        next_r.bitn = 4'h0;
                        if (r.left == 4'h0) begin
                            next_r.st = lsl_pkg::ss_idle;
                        end else begin
                            next_r.sh = lsl_pkg::lsl_tx_frame(tx_data);
                            next_r.tx_pop = 1'b1;
                            next_r.left = r.left - 4'h1;
                        end
                    end
                end
            end
            default: next_r.st = lsl_pkg::ss_idle;
        endcase
        if (!header_capture_input && r.low_cnt == 20'(BREAK_MIN_CYC - 1)) begin
            next_r.st = lsl_pkg::ss_brk;
        end
        // with the transceiver disabled the frame state machine is held in ss_idle
        if (!r.xcvr_en) begin
            next_r.st = lsl_pkg::ss_idle;
        end
        next_r.bus_o = (next_r.st == lsl_pkg::ss_tx) ? next_r.sh[0] : 1'b1;
        next_r.bus_oe = (next_r.st == lsl_pkg::ss_tx) & ~next_r.sh[0];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= SRST;
        end else begin
            r <= next_r;
        end
    end

    assign lnk.s_bus_o = r.bus_o;
    assign lnk.s_bus_oe = r.bus_oe;
    assign lnk.transceiver_enable_pin = r.xcvr_en;
    assign tx_pop = r.tx_pop;
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;
    assign rx_err = r.rx_err;
    assign hdr_valid = r.hdr_valid;
    assign hdr_id = r.hdr_id;
    assign bit_len = r.bit_len;
endmodule

// [bench/lsl_link_chk.sv]
// assertions on the wire between the master end and the slave end
`timescale 1ns/1ps
module lsl_link_chk #(
    parameter int BIT_CYC = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic m_bus_o,
    input wire logic m_bus_oe,
    input wire logic s_bus_o,
    input wire logic s_bus_oe,
    input wire logic transceiver_enable_pin,
    input wire logic bus_i
);
    logic m_pull;
    logic s_pull;
    logic [15:0] m_run;
    logic [15:0] s_run;
    logic [15:0] m_quiet;
    assign m_pull = m_bus_oe & ~m_bus_o;
    assign s_pull = transceiver_enable_pin & s_bus_oe & ~s_bus_o;
    // run lengths of each end's low drive, and idle time since the master let go
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_run <= 16'h0;
            s_run <= 16'h0;
            m_quiet <= 16'h0;
        end else begin
            m_run <= m_pull ? m_run + 16'h1 : 16'h0;
            s_run <= s_pull ? s_run + 16'h1 : 16'h0;
            m_quiet <= m_pull ? 16'h0 : (&m_quiet ? m_quiet : m_quiet + 16'h1);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_XCVR_RST: assert property ($rose(rst_n) |-> transceiver_enable_pin && !s_bus_oe)
        else $error("transceiver not enabled out of reset");
    AST_M_WHOLE_BITS: assert property ($fell(m_pull) |-> m_run % BIT_CYC == 0)
        else $error("master low run not whole bits");
    AST_S_WHOLE_BITS: assert property ($fell(s_pull) |-> s_run % BIT_CYC == 0)
        else $error("slave low run not whole bits");
    AST_S_RUN_MAX: assert property (s_run <= 9 * BIT_CYC)
        else $error("slave low run past stop bit");
    AST_M_RUN_MAX: assert property (m_run <= 13 * BIT_CYC)
        else $error("master low run too long");
    AST_M_BREAK_LEN: assert property ($fell(m_pull) && m_run > 9 * BIT_CYC |-> m_run == 13 * BIT_CYC)
        else $error("break length wrong");
    AST_XCVR_OFF_QUIET: assert property (!transceiver_enable_pin [*2] |-> !s_bus_oe)
        else $error("slave drives with transceiver off");
    AST_S_WAITS_IDLE: assert property ($rose(s_pull) |-> m_pull || m_quiet >= BIT_CYC)
        else $error("slave answer without idle bit");
    COV_BREAK: cover property ($fell(m_pull) && m_run == 13 * BIT_CYC);
    COV_SLAVE_ANSWER: cover property ($rose(s_pull));
    COV_XCVR_OFF: cover property (!transceiver_enable_pin && !bus_i);
endmodule

// [bench/testbench.sv]
// self-checking bench: master end and slave end joined by the bus interface
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, rst_n = 1'b0, link_enable = 1'b1, tbl_we = 1'b0, pub_ready = 1'b0;
    logic [5:0] tbl_id = 6'h0, hdr_id = 6'h0, s_hid, hv_id;
    lsl_pkg::lsl_kind_t tbl_kind = lsl_pkg::lsl_k_ignore;
    logic [3:0] tbl_len = 4'h0, hdr_len = 4'h0;
    logic hdr_req = 1'b0, hdr_send = 1'b0, fin = 1'b0, m_pop, s_pop, m_rv, s_rv, m_err, s_err;
    logic m_done, m_nr, m_busy, s_hv;
    logic [7:0] m_rx, s_rx, m_n = 8'h0, s_n = 8'h0;
    logic [15:0] bit_len;
    logic [7:0] mq[$], sq[$];
    int num_errors = 0, n_compared = 0, nresp = 0, nerr = 0;
    lsl_if lnk();
    lsl_master #(.BIT_CYC(16), .GAP_CYC(224)) u_lsl_master (.ref_clk(ref_clk), .rst_n(rst_n),
        .lnk(lnk.master_mp), .hdr_req(hdr_req), .hdr_id(hdr_id), .hdr_len(hdr_len),
        .hdr_send(hdr_send), .tx_data(8'h30 + m_n), .tx_pop(m_pop), .rx_data(m_rx),
        .rx_valid(m_rv), .rx_err(m_err), .done(m_done), .no_resp(m_nr), .busy(m_busy));
    // reset bit period kept off the link rate so only a real measurement gives 16
    lsl_slave #(.BIT_CYC(20), .BREAK_MIN_CYC(160)) u_lsl_slave (.ref_clk(ref_clk),
        .rst_n(rst_n), .lnk(lnk.slave_mp), .link_enable(link_enable), .tbl_we(tbl_we),
        .tbl_id(tbl_id), .tbl_kind(tbl_kind), .tbl_len(tbl_len), .pub_ready(pub_ready),
        .tx_data(8'hc0 + s_n), .tx_pop(s_pop), .rx_data(s_rx), .rx_valid(s_rv), .rx_err(s_err),
        .hdr_valid(s_hv), .hdr_id(s_hid), .bit_len(bit_len));
    lsl_link_chk #(.BIT_CYC(16)) u_lsl_link_chk (.ref_clk(ref_clk), .rst_n(rst_n),
        .m_bus_o(lnk.m_bus_o), .m_bus_oe(lnk.m_bus_oe), .s_bus_o(lnk.s_bus_o),
        .s_bus_oe(lnk.s_bus_oe), .transceiver_enable_pin(lnk.transceiver_enable_pin),
        .bus_i(lnk.bus_i));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // monitors
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (m_pop) m_n <= m_n + 8'h1;
        if (s_pop) s_n <= s_n + 8'h1;
        if (m_rv) mq.push_back(m_rx);
        if (s_rv) sq.push_back(s_rx);
        if (m_nr) nresp++;
        if (s_err || m_err) nerr++;
        if (s_hv) hv_id <= s_hid;
        if (m_done) fin <= 1'b1;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tw(input logic [5:0] id, input lsl_pkg::lsl_kind_t k, input logic [3:0] n);
        @(negedge ref_clk);
        tbl_we = 1'b1; tbl_id = id; tbl_kind = k; tbl_len = n;
        @(negedge ref_clk);
        tbl_we = 1'b0;
    endtask
    // one whole frame; byte counters restart so payloads are predictable
    task automatic frame(input logic [5:0] id, input logic [3:0] n, input logic snd);
        int i;
        @(negedge ref_clk);
        mq.delete(); sq.delete(); nresp = 0; nerr = 0; fin = 1'b0; m_n = 8'h0; s_n = 8'h0;
        hdr_id = id; hdr_len = n; hdr_send = snd; hdr_req = 1'b1;
        @(negedge ref_clk);
        hdr_req = 1'b0;
        chk(m_busy, 1'b1);
        for (i = 0; i < 4000 && !fin; i++) @(negedge ref_clk);
        chk(fin, 1'b1);
        chk(m_busy, 1'b0);
    endtask
    task automatic qchk(input logic [7:0] q[$], input logic [7:0] base, input int n);
        chk(q.size(), n[15:0]);
        foreach (q[i]) chk(q[i], base + i[7:0]);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_publish();
        repeat (2) begin
            frame(6'h05, 4'h2, 1'b0);
            qchk(mq, 8'hc0, 2);
            chk(hv_id, 6'h05);
            chk(nerr, 0);
            chk(bit_len, 16'h10);
        end
    endtask
    task automatic t_subscribe();
        frame(6'h06, 4'h3, 1'b1);
        qchk(sq, 8'h30, 3);
        chk(nerr, 0);
    endtask
    task automatic t_cond(input logic [5:0] id, input lsl_pkg::lsl_kind_t k);
        tw(id, k, 4'h1);
        pub_ready = 1'b0;
        frame(id, 4'h1, 1'b0);
        chk(nresp, 1);
        pub_ready = 1'b1;
        frame(id, 4'h1, 1'b0);
        qchk(mq, 8'hc0, 1);
    endtask
    task automatic t_ignore();
        frame(6'h09, 4'h2, 1'b0);
        chk(nresp, 1);
        chk(sq.size(), 0);
    endtask
    task automatic t_clash();
        frame(6'h0b, 4'h1, 1'b1);
        chk(nerr > 0, 1'b1);
        // after a collision the master polls with an unconditional frame
        frame(6'h0b, 4'h1, 1'b0);
        qchk(mq, 8'hc0, 1);
    endtask
    task automatic t_xcvr_off();
        @(negedge ref_clk);
        link_enable = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(lnk.transceiver_enable_pin, 1'b0);
        frame(6'h05, 4'h2, 1'b0);
        chk(nresp, 1);
        link_enable = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(lnk.transceiver_enable_pin, 1'b1);
    endtask
    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk(lnk.transceiver_enable_pin, 1'b1);
        chk(bit_len, 16'h14);
        tw(6'h05, lsl_pkg::lsl_k_publish, 4'h2);
        tw(6'h06, lsl_pkg::lsl_k_subscribe, 4'h3);
        tw(6'h0b, lsl_pkg::lsl_k_publish, 4'h1);
        t_publish();
        t_subscribe();
        t_cond(6'h07, lsl_pkg::lsl_k_event);
        t_cond(6'h08, lsl_pkg::lsl_k_diag);
        t_ignore();
        t_clash();
        t_xcvr_off();
        test_done();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        test_done();
    end
endmodule
